// File: hw/adc_port_pkg.sv
// Shared constants, encodings and state types of the converter serial port
package adc_port_pkg;
   // Clock and result
   localparam int CLK_MHZ  = 20;
   localparam int RESULT_W = 12;
   localparam int CTRL_W   = 8;
   // Control byte fields
   localparam int START_BIT = 7;
   localparam int CHAN_HI   = 6;
   localparam int CHAN_LO   = 4;
   localparam int RANGE_BIT = 3;
   localparam int POL_BIT   = 2;
   localparam int PD1_BIT   = 1;
   localparam int PD0_BIT   = 0;
   localparam logic [1:0] PD_INT  = 2'h0;
   localparam logic [1:0] PD_EXT  = 2'h1;
   localparam logic [1:0] PD_STBY = 2'h2;
   localparam logic [1:0] PD_FULL = 2'h3;
   // Frame positions in serial clocks
   localparam int TRACK_FALL = 6;
   localparam int ACQ_CLKS   = 6;
   localparam int HOLD_FALL  = TRACK_FALL + ACQ_CLKS;
   localparam int MSB_FALL   = HOLD_FALL + 1;
   localparam int EXT_CLKS   = MSB_FALL + RESULT_W;
   localparam int EXT_FIRST_SAMPLE = MSB_FALL + 1;
   // Internal timing, least times rounded up
   localparam int INT_ACQ_NS  = 2000;
   localparam int CONV_NS     = 7700;
   localparam int SCLK_PW_NS  = 200;
   localparam int INT_ACQ_CYC = (INT_ACQ_NS * CLK_MHZ + 999) / 1000;
   localparam int CONV_CYC    = (CONV_NS * CLK_MHZ + 999) / 1000;
   localparam int SCLK_HALF_CYC = (SCLK_PW_NS * CLK_MHZ + 999) / 1000;
   // Pin synchroniser reset: cs_n high, sclk low, din low, shutdown_n high
   localparam logic [3:0] PIN_RST = 4'h9;
   // Controller register map (byte addresses)
   localparam logic [4:0] REG_CMD      = 5'h00;
   localparam logic [4:0] REG_CFG      = 5'h04;
   localparam logic [4:0] REG_STAT     = 5'h08;
   localparam logic [4:0] REG_DATA     = 5'h0C;
   localparam logic [4:0] REG_IRQ_STAT = 5'h10;
   localparam logic [4:0] REG_IRQ_MASK = 5'h14;
   // States
   typedef enum logic [2:0] {
      D_IDLE = 3'h0, D_CTRL = 3'h1, D_ACQ = 3'h2, D_CONV = 3'h3, D_OUT = 3'h4
   } dev_state_e;
   typedef enum logic [2:0] {
      H_IDLE = 3'h0, H_LOW = 3'h1, H_HIGH = 3'h2, H_WAIT_LO = 3'h3,
      H_WAIT_HI = 3'h4, H_END = 3'h5
   } host_state_e;
endpackage

// File: hw/adc_link_if.sv
// Serial link between converter port and its controller
`timescale 1ns/1ps
interface adc_link_if;
   logic cs_n;
   logic sclk;
   logic din;
   logic shutdown_n;
   logic dout;
   logic dout_oe;
   logic strobe;
   logic strobe_oe;
   logic dout_w;
   logic strobe_w;

   // Undriven lines read low, as with a weak pull-down
   assign dout_w   = dout_oe & dout;
   assign strobe_w = strobe_oe & strobe;

   modport dev (input cs_n, sclk, din, shutdown_n,
                output dout, dout_oe, strobe, strobe_oe);
   modport host (output cs_n, sclk, din, shutdown_n,
                 input dout_w, strobe_w);
endinterface // adc_link_if

// File: hw/adc_port_dev.sv
// Converter end of the serial port: control byte, timing, result shift
//
// Register access over Avalon-MM and the register offsets were decided locally.
`timescale 1ns/1ps

// Functional notes
// - Input ignored unless chip select low
// - Data output released while chip select high
// - Data input sampled on serial clock rise
// - Output bits change on serial clock fall; internal mode puts the MSB out at conversion end
// - External mode: conversion paced by serial clock
// - Internal mode: strobe low after fall eight
// - External mode: one-period strobe before MSB
// - External mode: strobe driven only during select
// - Internal mode: host waits for strobe rise
// - Shutdown low holds full power-down
// - External acquisition and conversion scale with clock
// - First one after select is start bit
// - Byte: start, channel, range, polarity, mode
// - Mode codes: int, ext, standby, full down
// - Track from fall six for six clocks; internal mode tracks to fall eight, then ACQ_CYC clock cycles
module adc_port_dev #(
   parameter int ACQ_CYC = adc_port_pkg::INT_ACQ_CYC,
   parameter int CNV_CYC = adc_port_pkg::CONV_CYC
) (
   // Clock and reset
   input  wire logic                  clock,
   input  wire logic                  rstn,
   // Serial link
   adc_link_if.dev                    link,
   // Sampled analog value, caught at the start of hold
   input  wire logic [11:0]           sample_data,
   // Status towards the analog side
   output logic      [2:0]            channel_select,
   output logic                       range_select,
   output logic                       polarity_select,
   output logic                       ext_clock_mode,
   output logic                       tracking,
   output logic                       converting,
   output logic                       standby_power_down,
   output logic                       full_power_down
);
   localparam int TW = 9;
   initial begin
      if (ACQ_CYC < 1 || CNV_CYC < 1 || ACQ_CYC + CNV_CYC >= (1 << TW)) begin
         $error("adc_port_dev: timer counts out of range");
      end
   end

   localparam logic [4:0] F_TRACK = 5'(adc_port_pkg::TRACK_FALL);
   localparam logic [4:0] F_CTRL  = 5'(adc_port_pkg::CTRL_W);
   localparam logic [4:0] F_HOLD  = 5'(adc_port_pkg::HOLD_FALL);
   localparam logic [4:0] F_MSB   = 5'(adc_port_pkg::MSB_FALL);
   localparam logic [3:0] N_LAST  = 4'(adc_port_pkg::CTRL_W - 1);
   localparam logic [3:0] N_RES   = 4'(adc_port_pkg::RESULT_W);
   localparam logic [TW-1:0] T_ALL  = TW'(ACQ_CYC + CNV_CYC);
   localparam logic [TW-1:0] T_CONV = TW'(CNV_CYC);
   localparam logic [TW-1:0] T_ONE  = TW'(1);

   // Pin synchronisers: stage one feeds stage two only
   logic [3:0] meta_q;
   logic [3:0] sync_q;
   logic       sclk_q;
   wire  [3:0] pins = {link.cs_n, link.sclk, link.din, link.shutdown_n};

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         meta_q <= adc_port_pkg::PIN_RST;
         sync_q <= adc_port_pkg::PIN_RST;
         sclk_q <= 1'b0;
      end else begin
         meta_q <= pins;
         sync_q <= meta_q;
         sclk_q <= sync_q[2];
      end
   end

   wire cs_n_s = sync_q[3];
   wire sclk_s = sync_q[2];
   wire din_s  = sync_q[1];
   wire shutdown_n_s = sync_q[0];
   wire rise   = sclk_s & ~sclk_q;
   wire fall   = ~sclk_s & sclk_q;
   wire active = ~cs_n_s & shutdown_n_s;

   adc_port_pkg::dev_state_e st_q;
   logic [7:0]    ctl_q;
   logic [3:0]    cnt_q;
   logic [4:0]    fall_q;
   logic [TW-1:0] timer_q;
   logic [11:0]   res_q;
   logic [3:0]    out_q;
   logic          dout_q;
   logic          strobe_q;
   logic          ext_q;
   logic          stby_q;
   logic          fpd_q;
   logic [2:0]    chan_q;
   logic          rng_q;
   logic          pol_q;

   // Decode of the frame position
   wire       in_ctrl    = st_q == adc_port_pkg::D_CTRL;
   wire       in_acq     = st_q == adc_port_pkg::D_ACQ;
   wire       in_conv    = st_q == adc_port_pkg::D_CONV;
   wire       in_out     = st_q == adc_port_pkg::D_OUT;
   wire       start_seen = (st_q == adc_port_pkg::D_IDLE) & rise & din_s;
   wire [7:0] new_byte   = {ctl_q[6:0], din_s};
   wire       byte_done  = in_ctrl & rise & (cnt_q == N_LAST);
   wire       pd_req     = new_byte[adc_port_pkg::PD1_BIT];
   wire       ext_req    = new_byte[adc_port_pkg::PD0_BIT];
   wire [4:0] fall_nx    = fall_q + 5'h01;
   wire       fall_cnt   = fall & (in_ctrl | in_acq |
                           (in_conv & (fall_q < F_CTRL)));
   wire       timing     = in_conv & (fall_q == F_CTRL);
   wire       int_acq    = timing & (timer_q > T_CONV);
   wire       hold_now   = (in_acq & fall & (fall_nx == F_HOLD)) |
                           (timing & (timer_q == T_CONV));
   wire       msb_now    = (in_acq & fall & (fall_nx == F_MSB)) |
                           (timing & (timer_q == T_ONE));

   // Counters of the control byte and of falling edges
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ctl_q  <= 8'h00;
         cnt_q  <= 4'h0;
         fall_q <= 5'h00;
      end else if (!active) begin
         cnt_q  <= 4'h0;
         fall_q <= 5'h00;
      end else if (start_seen) begin
         ctl_q  <= 8'h01;
         cnt_q  <= 4'h1;
         fall_q <= 5'h00;
      end else begin
         if (in_ctrl & rise) begin
            ctl_q <= new_byte;
            cnt_q <= cnt_q + 4'h1;
         end
         if (fall_cnt) begin
            fall_q <= fall_nx;
         end
      end
   end

   // Frame sequencing
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         st_q <= adc_port_pkg::D_IDLE;
      end else if (!active) begin
         st_q <= adc_port_pkg::D_IDLE;
      end else begin
         case (st_q)
            adc_port_pkg::D_IDLE: begin
               if (start_seen) begin
                  st_q <= adc_port_pkg::D_CTRL;
               end
            end
            adc_port_pkg::D_CTRL: begin
               if (byte_done) begin
                  st_q <= pd_req ? adc_port_pkg::D_IDLE :
                          ext_req ? adc_port_pkg::D_ACQ :
                          adc_port_pkg::D_CONV;
               end
            end
            adc_port_pkg::D_ACQ,
            adc_port_pkg::D_CONV: begin
               if (msb_now) begin
                  st_q <= adc_port_pkg::D_OUT;
               end
            end
            adc_port_pkg::D_OUT: begin
               if (fall & (out_q == N_RES)) begin
                  st_q <= adc_port_pkg::D_IDLE;
               end
            end
            default: st_q <= adc_port_pkg::D_IDLE;
         endcase
      end
   end

   // Internal conversion timer; stops whenever the frame is dropped
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         timer_q <= '0;
      end else if (in_conv & fall & (fall_nx == F_CTRL)) begin
         timer_q <= T_ALL;
      end else if (timing & (timer_q != '0)) begin
         timer_q <= timer_q - T_ONE;
      end
   end

   // Strobe, result capture and output shifting
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         strobe_q <= 1'b1;
         dout_q   <= 1'b0;
         res_q    <= 12'h000;
         out_q    <= 4'h0;
      end else if (!active) begin
         strobe_q <= ~ext_q;
         dout_q   <= 1'b0;
      end else begin
         // An idle strobe left high by internal mode must not run into the pulse
         if (byte_done & ext_req & ~pd_req) begin
            strobe_q <= 1'b0;
         end
         if (in_conv & fall & (fall_nx == F_CTRL)) begin
            strobe_q <= 1'b0;
         end
         if (hold_now) begin
            res_q <= sample_data;
            if (in_acq) begin
               strobe_q <= 1'b1;
            end
         end else if (msb_now) begin
            strobe_q <= ~in_acq;
            dout_q   <= res_q[11];
            res_q    <= {res_q[10:0], 1'b0};
            out_q    <= 4'h1;
         end else if (in_out & fall) begin
            dout_q <= (out_q == N_RES) ? 1'b0 : res_q[11];
            res_q  <= {res_q[10:0], 1'b0};
            out_q  <= out_q + 4'h1;
         end
      end
   end

   // Mode and channel settings from each finished control byte
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ext_q  <= 1'b0;
         stby_q <= 1'b0;
         fpd_q  <= 1'b0;
         chan_q <= 3'h0;
         rng_q  <= 1'b0;
         pol_q  <= 1'b0;
      end else if (active & byte_done) begin
         chan_q <= new_byte[adc_port_pkg::CHAN_HI:adc_port_pkg::CHAN_LO];
         rng_q  <= new_byte[adc_port_pkg::RANGE_BIT];
         pol_q  <= new_byte[adc_port_pkg::POL_BIT];
         stby_q <= pd_req & ~ext_req;
         fpd_q  <= pd_req & ext_req;
         if (!pd_req) begin
            ext_q <= ext_req;
         end
      end
   end

   // Pin drivers follow the synchronised select
   assign link.dout      = dout_q;
   assign link.dout_oe   = ~cs_n_s;
   assign link.strobe    = strobe_q;
   assign link.strobe_oe = ~ext_q | ~cs_n_s;

   assign channel_select     = chan_q;
   assign range_select       = rng_q;
   assign polarity_select    = pol_q;
   assign ext_clock_mode     = ext_q;
   assign tracking           = (in_ctrl & (fall_q >= F_TRACK)) |
                               (in_acq & (fall_q < F_HOLD)) |
                               (in_conv & ~timing) | int_acq;
   assign converting         = (in_acq & (fall_q >= F_HOLD)) |
                               (timing & ~int_acq) |
                               (in_out & ext_q & (out_q < N_RES));
   assign standby_power_down = stby_q;
   assign full_power_down    = fpd_q | ~shutdown_n_s;
endmodule // adc_port_dev

// File: hw/adc_port_host.sv
// Controller end: Avalon-MM registers driving the serial link
`timescale 1ns/1ps
module adc_port_host #(
   parameter int HALF_CYC = adc_port_pkg::SCLK_HALF_CYC
) (
   // Clock and reset
   input  wire logic                  clock,
   input  wire logic                  rstn,
   // Avalon-MM slave
   input  wire logic [4:0]            address,
   input  wire logic                  read,
   input  wire logic                  write,
   input  wire logic [31:0]           writedata,
   input  wire logic [3:0]            byteenable,
   output logic      [31:0]           readdata,
   output logic                       waitrequest,
   // Interrupt
   output logic                       irq,
   // Serial link
   adc_link_if.host                   link
);
   initial begin
      if (HALF_CYC < 1 || HALF_CYC > 255) begin
         $error("adc_port_host: HALF_CYC out of range");
      end
   end

   localparam logic [7:0] DIV_LOAD = 8'(HALF_CYC - 1);
   localparam logic [4:0] N_CTRL   = 5'(adc_port_pkg::CTRL_W);
   localparam logic [4:0] N_EXT    = 5'(adc_port_pkg::EXT_CLKS);
   localparam logic [4:0] N_SAMP   = 5'(adc_port_pkg::EXT_FIRST_SAMPLE);
   localparam logic [4:0] N_RES    = 5'(adc_port_pkg::RESULT_W);

   // Return pins pass two flip-flops
   logic [1:0] meta_q;
   logic [1:0] sync_q;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         meta_q <= 2'h0;
         sync_q <= 2'h0;
      end else begin
         meta_q <= {link.dout_w, link.strobe_w};
         sync_q <= meta_q;
      end
   end
   wire dout_s   = sync_q[1];
   wire strobe_s = sync_q[0];

   adc_port_pkg::host_state_e st_q;
   logic [7:0]  div_q;
   logic [4:0]  cnt_q;
   logic        ph2_q;
   logic [1:0]  mode_q;
   logic [7:0]  tx_q;
   logic [11:0] rx_q;
   logic [11:0] result_q;
   logic        cs_n_q;
   logic        sclk_q;
   logic        shutdown_n_q;
   logic        stat_q;
   logic        mask_q;
   logic        ack_q;
   logic [31:0] rdata_q;

   // Bus decode; a write lands on the edge where waitrequest is low
   wire wr_en    = write & ack_q & byteenable[0];
   wire wr_cmd   = wr_en & (address == adc_port_pkg::REG_CMD);
   wire wr_cfg   = wr_en & (address == adc_port_pkg::REG_CFG);
   wire wr_istat = wr_en & (address == adc_port_pkg::REG_IRQ_STAT);
   wire wr_imask = wr_en & (address == adc_port_pkg::REG_IRQ_MASK);
   wire idle     = st_q == adc_port_pkg::H_IDLE;
   wire start    = wr_cmd & idle;
   wire tick     = div_q == 8'h00;
   wire in_high  = st_q == adc_port_pkg::H_HIGH;
   wire ext_m    = mode_q == adc_port_pkg::PD_EXT;
   wire sample   = (ext_m & (cnt_q >= N_SAMP)) | ph2_q;
   wire finish   = (ext_m & (cnt_q == N_EXT)) |
                   (mode_q[1] & (cnt_q == N_CTRL)) |
                   (ph2_q & (cnt_q == N_RES));
   wire wait_int = (mode_q == adc_port_pkg::PD_INT) & ~ph2_q &
                   (cnt_q == N_CTRL);
   wire done     = (st_q == adc_port_pkg::H_END) & tick;
   wire [31:0] rd_mux =
      (address == adc_port_pkg::REG_CFG)      ? {31'h0, shutdown_n_q} :
      (address == adc_port_pkg::REG_STAT)     ? {30'h0, strobe_s, ~idle} :
      (address == adc_port_pkg::REG_DATA)     ? {20'h0, result_q} :
      (address == adc_port_pkg::REG_IRQ_STAT) ? {31'h0, stat_q} :
      (address == adc_port_pkg::REG_IRQ_MASK) ? {31'h0, mask_q} : 32'h0;

   // One wait state on every access
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h0;
      end else begin
         ack_q <= (read | write) & ~ack_q;
         if (read & ~ack_q) begin
            rdata_q <= rd_mux;
         end
      end
   end

   // Half-period divider makes the link clock
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         div_q <= 8'h00;
      end else if (idle | tick | (st_q == adc_port_pkg::H_WAIT_HI)) begin
         div_q <= DIV_LOAD;
      end else begin
         div_q <= div_q - 8'h01;
      end
   end

   // Frame sequencer; din changes on the falling edge
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         st_q   <= adc_port_pkg::H_IDLE;
         cnt_q  <= 5'h00;
         ph2_q  <= 1'b0;
         mode_q <= adc_port_pkg::PD_INT;
         tx_q   <= 8'h00;
         rx_q   <= 12'h000;
         cs_n_q <= 1'b1;
         sclk_q <= 1'b0;
      end else begin
         case (st_q)
            adc_port_pkg::H_IDLE: begin
               if (start) begin
                  tx_q   <= {1'b1, writedata[6:0]};
                  mode_q <= writedata[1:0];
                  cnt_q  <= 5'h00;
                  ph2_q  <= 1'b0;
                  cs_n_q <= 1'b0;
                  st_q   <= adc_port_pkg::H_LOW;
               end
            end
            adc_port_pkg::H_LOW: begin
               if (tick) begin
                  sclk_q <= 1'b1;
                  cnt_q  <= cnt_q + 5'h01;
                  st_q   <= adc_port_pkg::H_HIGH;
               end
            end
            adc_port_pkg::H_HIGH: begin
               if (tick) begin
                  sclk_q <= 1'b0;
                  tx_q   <= {tx_q[6:0], 1'b0};
                  if (sample) begin
                     rx_q <= {rx_q[10:0], dout_s};
                  end
                  st_q <= finish ? adc_port_pkg::H_END :
                          wait_int ? adc_port_pkg::H_WAIT_LO :
                          adc_port_pkg::H_LOW;
               end
            end
            adc_port_pkg::H_WAIT_LO: begin
               if (!strobe_s) begin
                  st_q <= adc_port_pkg::H_WAIT_HI;
               end
            end
            adc_port_pkg::H_WAIT_HI: begin
               if (strobe_s) begin
                  cnt_q <= 5'h00;
                  ph2_q <= 1'b1;
                  st_q  <= adc_port_pkg::H_LOW;
               end
            end
            adc_port_pkg::H_END: begin
               if (tick) begin
                  cs_n_q <= 1'b1;
                  st_q   <= adc_port_pkg::H_IDLE;
               end
            end
            default: st_q <= adc_port_pkg::H_IDLE;
         endcase
      end
   end

   // Result, configuration and interrupt registers; set beats clear
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         result_q <= 12'h000;
         shutdown_n_q   <= 1'b1;
         stat_q   <= 1'b0;
         mask_q   <= 1'b0;
      end else begin
         if (done & (ph2_q | ext_m)) begin
            result_q <= rx_q;
         end
         if (wr_cfg) begin
            shutdown_n_q <= writedata[0];
         end
         if (wr_imask) begin
            mask_q <= writedata[0];
         end
         stat_q <= done | (stat_q & ~(wr_istat & writedata[0]));
      end
   end

   assign readdata        = rdata_q;
   assign waitrequest     = (read | write) & ~ack_q;
   assign irq             = stat_q & mask_q;
   assign link.cs_n       = cs_n_q;
   assign link.sclk       = sclk_q;
   assign link.din        = tx_q[7];
   assign link.shutdown_n = shutdown_n_q;
endmodule // adc_port_host

// File: sim/adc_link_props.sv
// Assertions on the serial link between converter port and controller
`timescale 1ns/1ps
module adc_link_props (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Link
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic din,
   input wire logic dout,
   input wire logic dout_oe,
   input wire logic strobe,
   input wire logic strobe_oe
);
   logic       sclk_q;
   logic [4:0] falls_q;
   logic [4:0] rises_q;
   logic [7:0] byte_q;
   logic       ext_q;
   wire        sfall = sclk_q & ~sclk;
   wire        srise = ~sclk_q & sclk;
   // Frame position is rebuilt from the wire alone, so it needs no taps
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sclk_q  <= 1'b0;
         falls_q <= 5'h0;
         rises_q <= 5'h0;
         byte_q  <= 8'h0;
         ext_q   <= 1'b0;
      end else begin
         sclk_q  <= sclk;
         falls_q <= cs_n ? 5'h0 : falls_q + 5'(sfall);
         rises_q <= cs_n ? 5'h0 : rises_q + 5'(srise);
         if (srise && rises_q < 5'h8) byte_q <= {byte_q[6:0], din};
         if (!cs_n && rises_q == 5'h8 && !byte_q[1]) ext_q <= byte_q[0];
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   AST_DOUT_OFF: assert property (cs_n [*4] |-> !dout_oe)
      else $error("dout driven while deselected");
   AST_DIN_HELD: assert property ($rose(sclk) |-> $stable(din))
      else $error("din moved at sclk rise");
   AST_DOUT_LOW: assert property (dout_oe && $past(dout_oe) &&
      $changed(dout) |-> !sclk) else $error("dout moved in high phase");
   AST_INT_STRB: assert property ($fell(sclk) && !cs_n &&
      falls_q == 5'h7 && byte_q[1:0] == 2'h0 |-> ##[1:6] !strobe)
      else $error("strobe late after eighth fall");
   AST_INT_WAIT: assert property (!cs_n && !ext_q && strobe_oe &&
      !strobe |-> !$rose(sclk)) else $error("sclk rose during conversion");
   AST_EXT_ONE: assert property ($rose(strobe) && strobe_oe &&
      ext_q |-> strobe [*8] ##1 !strobe) else $error("strobe width");
   AST_EXT_POS: assert property ($rose(strobe) && strobe_oe &&
      ext_q |-> falls_q == 5'hC) else $error("strobe not at fall 12");
   AST_EXT_OFF: assert property (ext_q && cs_n [*4] |-> !strobe_oe)
      else $error("strobe driven while deselected");
   cover property ($rose(strobe) && strobe_oe && ext_q);
   cover property ($fell(strobe) && !ext_q && !cs_n);
   cover property ($rose(cs_n));
endmodule // adc_link_props

// File: sim/tb_adc_serial_control_port.sv
// Self-checking bench joining both ends of the converter serial link
`timescale 1ns/1ps
module tb_adc_serial_control_port;
   logic        clock;
   logic        rstn;
   logic [4:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        irq;
   logic [11:0] sample_data;
   logic [2:0]  channel_select;
   logic        range_select, polarity_select, ext_clock_mode;
   logic        standby_power_down, full_power_down;
   logic        tracking, converting;
   logic        ext_exp;
   int          n_mismatch;
   int          samples_checked;

   adc_link_if link ();
   // Short acquisition and conversion keep the run brief
   adc_port_dev #(.ACQ_CYC(4), .CNV_CYC(8)) adc_port_dev_i (
      .clock(clock), .rstn(rstn), .link(link), .sample_data(sample_data),
      .channel_select(channel_select), .range_select(range_select),
      .polarity_select(polarity_select), .ext_clock_mode(ext_clock_mode),
      .tracking(tracking), .converting(converting),
      .standby_power_down(standby_power_down),
      .full_power_down(full_power_down));
   adc_port_host #(.HALF_CYC(4)) adc_port_host_i (
      .clock(clock), .rstn(rstn), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(4'hF),
      .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
      .link(link));
   adc_link_props adc_link_props_i (
      .clock(clock), .rstn(rstn), .cs_n(link.cs_n), .sclk(link.sclk),
      .din(link.din), .dout(link.dout), .dout_oe(link.dout_oe),
      .strobe(link.strobe), .strobe_oe(link.strobe_oe));

   always #25 clock = ~clock;

   task automatic chk(input string what, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Request stands until a rising edge samples waitrequest low
   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge clock);
      address   <= a;
      writedata <= d;
      write     <= wr;
      read      <= !wr;
      do begin
         @(posedge clock);
      end while (waitrequest !== 1'b0);
      q = readdata;
      write <= 1'b0;
      read  <= 1'b0;
   endtask

   task automatic conv(input logic [2:0] ch, input logic [1:0] pd,
                       input logic [11:0] smp);
      logic [31:0] q;
      sample_data <= smp;
      bus(1'b1, adc_port_pkg::REG_CMD, {25'h0, ch, ch[0], ch[1], pd}, q);
      // A frame that never ends is caught by the watchdog
      q = 32'h1;
      while (q[0] !== 1'b0) begin
         bus(1'b0, adc_port_pkg::REG_STAT, 32'h0, q);
      end
      if (!pd[1]) ext_exp = pd[0];
      chk("chan", channel_select, ch);
      chk("range", range_select, ch[0]);
      chk("pol", polarity_select, ch[1]);
      chk("ext", ext_clock_mode, ext_exp);
      chk("stby", standby_power_down, pd == 2'h2);
      chk("full", full_power_down, pd == 2'h3);
      chk("tracking", tracking, 1'b0);
      chk("converting", converting, 1'b0);
      if (!pd[1]) begin
         bus(1'b0, adc_port_pkg::REG_DATA, 32'h0, q);
         chk("data", q, {20'h0, smp});
      end
   endtask

   task automatic reg_wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
      repeat (4) @(negedge clock);
   endtask

   task automatic reset_values();
      logic [31:0] q;
      bus(1'b0, adc_port_pkg::REG_CFG, 32'h0, q);
      chk("cfg", q, 32'h1);
      bus(1'b1, 5'h18, 32'hFF, q);
      bus(1'b0, 5'h18, 32'h0, q);
      chk("unmapped", q, 32'h0);
      chk("irq", irq, 1'b0);
      chk("dout idle", link.dout_w, 1'b0);
   endtask

   task automatic irq_test();
      logic [31:0] q;
      reg_wr(adc_port_pkg::REG_IRQ_MASK, 32'h0);
      chk("irq masked", irq, 1'b0);
      reg_wr(adc_port_pkg::REG_IRQ_MASK, 32'h1);
      chk("irq open", irq, 1'b1);
      reg_wr(adc_port_pkg::REG_IRQ_STAT, 32'h1);
      chk("irq cleared", irq, 1'b0);
      bus(1'b0, adc_port_pkg::REG_IRQ_STAT, 32'h0, q);
      chk("irq stat", q, 32'h0);
   endtask

   task automatic shutdown_test();
      reg_wr(adc_port_pkg::REG_CFG, 32'h0);
      chk("shutdown_n pin", link.shutdown_n, 1'b0);
      chk("full shutdown_n", full_power_down, 1'b1);
      reg_wr(adc_port_pkg::REG_CFG, 32'h1);
      chk("full run", full_power_down, 1'b0);
   endtask

   task automatic conclude();
      $display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      #1000000;
      n_mismatch++;
      conclude();
   end

   initial begin
      clock = 1'b0;
      rstn = 1'b0;
      address = 5'h0;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      sample_data = 12'h0;
      ext_exp = 1'b0;
      n_mismatch = 0;
      samples_checked = 0;
      repeat (10) @(posedge clock);
      rstn <= 1'b1;
      repeat (3) @(posedge clock);
      reset_values();
      conv(3'h1, 2'h2, 12'h0F0);
      conv(3'h6, 2'h3, 12'h123);
      conv(3'h5, 2'h1, 12'hA5C);
      conv(3'h7, 2'h1, 12'hFFF);
      conv(3'h2, 2'h0, 12'h5A3);
      conv(3'h0, 2'h0, 12'h801);
      irq_test();
      shutdown_test();
      conclude();
   end
endmodule // tb_adc_serial_control_port
